// *** hdl/bkd_pkg.sv ***
// Package of constants and types for the barcode keystroke decoder.
package bkd_pkg;

  // ----------------------------------------------------------------------
  // Byte values of the scanner code set
  // ----------------------------------------------------------------------
  localparam logic [7:0] BYTE_PREFIX = 8'h01;
  localparam logic [7:0] BYTE_LEFT = 8'h08;
  localparam logic [7:0] BYTE_DOWN = 8'h0a;
  localparam logic [7:0] BYTE_UP = 8'h0b;
  localparam logic [7:0] BYTE_RIGHT = 8'h0c;
  localparam logic [7:0] BYTE_ENTER = 8'h0d;
  localparam logic [7:0] BYTE_ESC = 8'h1b;
  localparam logic [7:0] BYTE_HOME = 8'h1e;
  localparam logic [7:0] BYTE_ESC_PGUP = 8'h4a;
  localparam logic [7:0] BYTE_ESC_PGDN = 8'h4b;
  localparam logic [7:0] BYTE_ESC_END = 8'h54;
  localparam logic [7:0] BYTE_ESC_DEL = 8'h57;
  localparam logic [7:0] BYTE_SEL_FIRST = 8'h40;
  localparam logic [7:0] BYTE_SEL_LAST = 8'h49;
  localparam logic [7:0] BYTE_SEL_DELAY = 8'h60;
  localparam logic [7:0] BYTE_SEL_EMPLOYEE = 8'h61;
  localparam logic [7:0] BYTE_SEL_SCRAP = 8'h63;
  localparam logic [7:0] BYTE_DIGIT_0 = 8'h30;
  localparam logic [7:0] BYTE_DIGIT_9 = 8'h39;

  // ----------------------------------------------------------------------
  // Field sizes and timing
  // ----------------------------------------------------------------------
  localparam int FIELD_DIGITS = 7;
  localparam logic [2:0] LEN_DELAY = 3'h2;
  localparam logic [2:0] LEN_EMPLOYEE = 3'h7;
  localparam logic [2:0] LEN_SCRAP = 3'h2;
  localparam int CLK_MHZ = 250;
  localparam int ESC_WAIT_US = 1000;
  localparam int ESC_WAIT_CYCLES = ESC_WAIT_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    KEY_ENTER = 5'h00, KEY_STATUS = 5'h01, KEY_RIGHT = 5'h02,
    KEY_LEFT = 5'h03, KEY_UP = 5'h04, KEY_DOWN = 5'h05,
    KEY_HOME = 5'h06, KEY_END = 5'h07, KEY_DELETE = 5'h08,
    KEY_PAGE_UP = 5'h09, KEY_PAGE_DOWN = 5'h0a,
    KEY_HELP = 5'h0b, KEY_SETUP = 5'h0c, KEY_PROGRAM = 5'h0d,
    KEY_FOOTAGE = 5'h0e, KEY_NEXT_LINE = 5'h0f, KEY_SKIP_LINE = 5'h10,
    KEY_ADD_LINE = 5'h11, KEY_DEL_LINE = 5'h12, KEY_INC_QTY = 5'h13,
    KEY_DEC_QTY = 5'h14
  } bkd_key_t;

  typedef enum logic [1:0] {
    HOT_DELAY = 2'h0, HOT_EMPLOYEE = 2'h1, HOT_SCRAP = 2'h2
  } bkd_hot_kind_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, ST_ESC = 5'b00010, ST_PREFIX = 5'b00100,
    ST_SELECT = 5'b01000, ST_DIGITS = 5'b10000
  } bkd_state_t;

  // Scanner byte as it arrives.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } bkd_byte_t;

  // Decoded keypad stroke.
  typedef struct packed {
    logic valid;
    bkd_key_t key;
  } bkd_key_evt_t;

  // Hot key entry; digit 0 of the field is the first digit scanned,
  // packed as BCD in the top nibble used, last digit in bits 3:0.
  typedef struct packed {
    logic valid;
    bkd_hot_kind_t kind;
    logic [4*FIELD_DIGITS-1:0] bcd;
  } bkd_hot_evt_t;

endpackage : bkd_pkg

// *** hdl/bkd_digit_field.sv ***
// BCD shift register that collects the digits of a hot key field.
`timescale 1ns/1ps
module bkd_digit_field #(
  parameter int DIGITS = 7
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic shift,
  input wire logic [3:0] digit,
  // Field
  output logic [4*DIGITS-1:0] bcd,
  output logic [2:0] count
);

  logic [4*DIGITS-1:0] bcd_reg;
  logic [2:0] count_reg;
  wire [4*DIGITS-1:0] bcd_next = {bcd_reg[4*DIGITS-5:0], digit};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bcd_reg <= '0;
      count_reg <= 3'h0;
    end else if (clear) begin
      bcd_reg <= '0;
      count_reg <= 3'h0;
    end else if (shift) begin
      bcd_reg <= bcd_next;
      count_reg <= count_reg + 3'h1;
    end
  end

  assign bcd = bcd_reg;
  assign count = count_reg;

endmodule : bkd_digit_field

// *** hdl/bkd_decoder.sv ***
// Barcode keystroke decoder: scanner byte stream to keypad events.
//
// Contract
// - Every three-digit code is one byte of that decimal value.
// - 013, 027, 012, 008, 011, 010, 030 and pairs of 027 each map a key.
// - 001, selector 064..073, 013 selects Help to Decrease Quantity.
// - 001 096 013, two digits, 013 delivers a delay code.
// - 001 097 013, seven digits, 013 delivers an employee code.
// - 001 099 013, two digits, 013 delivers a scrap code.
`timescale 1ns/1ps
module bkd_decoder #(
  parameter int ESC_WAIT = bkd_pkg::ESC_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Scanner byte stream
  input wire bkd_pkg::bkd_byte_t scan_in,
  output logic scan_ready,
  // Keypad side
  output bkd_pkg::bkd_key_evt_t key_out,
  output bkd_pkg::bkd_hot_evt_t hot_out,
  output logic seq_drop
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  bkd_pkg::bkd_state_t state_reg, state_next;
  logic [7:0] sel_reg, sel_next;
  logic [7:0] replay_reg, replay_next;
  logic replay_valid_reg, replay_valid_next;
  logic [2:0] len_reg, len_next;
  logic [31:0] wait_reg, wait_next;
  bkd_pkg::bkd_key_evt_t key_reg, key_next;
  bkd_pkg::bkd_hot_evt_t hot_reg, hot_next;
  logic drop_reg, drop_next;
  logic ready_reg;
  logic field_clear, field_shift;
  logic [4*bkd_pkg::FIELD_DIGITS-1:0] field_bcd;
  logic [2:0] field_count;

  // ----------------------------------------------------------------------
  // Byte selection and classification
  // ----------------------------------------------------------------------
  // A byte held back after a lone escape is replayed before new input.
  // A byte offered while ready is low is not taken, so the scanner keeps it.
  wire in_valid = replay_valid_reg | (scan_in.valid & ready_reg);
  wire [7:0] in_byte = replay_valid_reg ? replay_reg : scan_in.data;
  wire is_digit = (in_byte >= bkd_pkg::BYTE_DIGIT_0) &&
                  (in_byte <= bkd_pkg::BYTE_DIGIT_9);
  wire [7:0] digit_off = in_byte - bkd_pkg::BYTE_DIGIT_0;
  wire [7:0] sel_off = sel_reg - bkd_pkg::BYTE_SEL_FIRST;
  wire sel_is_fn = (sel_reg >= bkd_pkg::BYTE_SEL_FIRST) &&
                   (sel_reg <= bkd_pkg::BYTE_SEL_LAST);
  wire is_enter = in_byte == bkd_pkg::BYTE_ENTER;
  wire esc_expired = wait_reg == 32'(ESC_WAIT - 1);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    replay_next = replay_reg;
    replay_valid_next = 1'b0;
    len_next = len_reg;
    wait_next = 32'h0;
    key_next = '0;
    hot_next = '0;
    hot_next.bcd = hot_reg.bcd;
    hot_next.kind = hot_reg.kind;
    key_next.key = key_reg.key;
    drop_next = 1'b0;
    field_clear = 1'b0;
    field_shift = 1'b0;
    case (state_reg)
      bkd_pkg::ST_IDLE: begin
        if (in_valid) begin
          key_next.valid = 1'b1;
          case (in_byte)
            bkd_pkg::BYTE_ENTER: key_next.key = bkd_pkg::KEY_ENTER;
            bkd_pkg::BYTE_RIGHT: key_next.key = bkd_pkg::KEY_RIGHT;
            bkd_pkg::BYTE_LEFT: key_next.key = bkd_pkg::KEY_LEFT;
            bkd_pkg::BYTE_UP: key_next.key = bkd_pkg::KEY_UP;
            bkd_pkg::BYTE_DOWN: key_next.key = bkd_pkg::KEY_DOWN;
            bkd_pkg::BYTE_HOME: key_next.key = bkd_pkg::KEY_HOME;
            bkd_pkg::BYTE_ESC: begin
              key_next.valid = 1'b0;
              state_next = bkd_pkg::ST_ESC;
            end
            bkd_pkg::BYTE_PREFIX: begin
              key_next.valid = 1'b0;
              state_next = bkd_pkg::ST_PREFIX;
            end
            default: begin
              key_next.valid = 1'b0;
              drop_next = 1'b1;
            end
          endcase
        end
      end
      bkd_pkg::ST_ESC: begin
        // A lone escape is Status; it is resolved by the next byte or,
        // if the scan ends there, by the wait running out.
        wait_next = wait_reg + 32'h1;
        if (in_valid) begin
          state_next = bkd_pkg::ST_IDLE;
          key_next.valid = 1'b1;
          case (in_byte)
            bkd_pkg::BYTE_ESC_END: key_next.key = bkd_pkg::KEY_END;
            bkd_pkg::BYTE_ESC_DEL: key_next.key = bkd_pkg::KEY_DELETE;
            bkd_pkg::BYTE_ESC_PGUP: key_next.key = bkd_pkg::KEY_PAGE_UP;
            bkd_pkg::BYTE_ESC_PGDN: key_next.key = bkd_pkg::KEY_PAGE_DOWN;
            default: begin
              key_next.key = bkd_pkg::KEY_STATUS;
              replay_next = in_byte;
              replay_valid_next = 1'b1;
            end
          endcase
        end else if (esc_expired) begin
          state_next = bkd_pkg::ST_IDLE;
          key_next.valid = 1'b1;
          key_next.key = bkd_pkg::KEY_STATUS;
        end
      end
      bkd_pkg::ST_PREFIX: begin
        if (in_valid) begin
          sel_next = in_byte;
          state_next = bkd_pkg::ST_SELECT;
        end
      end
      bkd_pkg::ST_SELECT: begin
        if (in_valid) begin
          state_next = bkd_pkg::ST_IDLE;
          field_clear = 1'b1;
          if (!is_enter) begin
            drop_next = 1'b1;
          end else if (sel_is_fn) begin
            key_next.valid = 1'b1;
            key_next.key = bkd_pkg::bkd_key_t'(
              5'(bkd_pkg::KEY_HELP) + sel_off[4:0]);
          end else if (sel_reg == bkd_pkg::BYTE_SEL_DELAY) begin
            state_next = bkd_pkg::ST_DIGITS;
            len_next = bkd_pkg::LEN_DELAY;
            hot_next.kind = bkd_pkg::HOT_DELAY;
          end else if (sel_reg == bkd_pkg::BYTE_SEL_EMPLOYEE) begin
            state_next = bkd_pkg::ST_DIGITS;
            len_next = bkd_pkg::LEN_EMPLOYEE;
            hot_next.kind = bkd_pkg::HOT_EMPLOYEE;
          end else if (sel_reg == bkd_pkg::BYTE_SEL_SCRAP) begin
            state_next = bkd_pkg::ST_DIGITS;
            len_next = bkd_pkg::LEN_SCRAP;
            hot_next.kind = bkd_pkg::HOT_SCRAP;
          end else begin
            drop_next = 1'b1;
          end
        end
      end
      bkd_pkg::ST_DIGITS: begin
        if (in_valid) begin
          if (field_count == len_reg) begin
            state_next = bkd_pkg::ST_IDLE;
            if (is_enter) begin
              hot_next.valid = 1'b1;
              hot_next.bcd = field_bcd;
            end else begin
              drop_next = 1'b1;
            end
          end else if (is_digit) begin
            field_shift = 1'b1;
          end else begin
            state_next = bkd_pkg::ST_IDLE;
            drop_next = 1'b1;
          end
        end
      end
      default: begin
        state_next = bkd_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= bkd_pkg::ST_IDLE;
      sel_reg <= 8'h00;
      replay_reg <= 8'h00;
      replay_valid_reg <= 1'b0;
      len_reg <= 3'h0;
      wait_reg <= 32'h0;
      key_reg <= '0;
      hot_reg <= '0;
      drop_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      replay_reg <= replay_next;
      replay_valid_reg <= replay_valid_next;
      len_reg <= len_next;
      wait_reg <= wait_next;
      key_reg <= key_next;
      hot_reg <= hot_next;
      drop_reg <= drop_next;
      ready_reg <= !replay_valid_next;
    end
  end

  // ----------------------------------------------------------------------
  // Digit field
  // ----------------------------------------------------------------------
  bkd_digit_field #(
    .DIGITS(bkd_pkg::FIELD_DIGITS)
  ) u_field (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(field_clear),
    .shift(field_shift),
    .digit(digit_off[3:0]),
    .bcd(field_bcd),
    .count(field_count)
  );

  assign scan_ready = ready_reg;
  assign key_out = key_reg;
  assign hot_out = hot_reg;
  assign seq_drop = drop_reg;

endmodule : bkd_decoder

// *** verif/bkd_decoder_assertions.sv ***
// Port assertions for the barcode keystroke decoder.
`timescale 1ns/1ps
module bkd_decoder_checker #(
  parameter int ESC_WAIT = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched ports
  input wire bkd_pkg::bkd_byte_t scan_in,
  input wire logic scan_ready,
  input wire bkd_pkg::bkd_key_evt_t key_out,
  input wire bkd_pkg::bkd_hot_evt_t hot_out,
  input wire logic seq_drop
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic kv = key_out.valid;
  wire logic hv = hot_out.valid;
  wire logic [4:0] key = key_out.key;
  wire logic [7:0] dat = scan_in.data;
  wire logic took = scan_in.valid && scan_ready;

  a_home_cause: assert property (
    kv && key == bkd_pkg::KEY_HOME |->
    $past(dat) == bkd_pkg::BYTE_HOME || $past(dat, 2) == bkd_pkg::BYTE_HOME
  ) else $error("home key without home byte");
  a_end_pair: assert property (
    kv && key == bkd_pkg::KEY_END |->
    $past(took) && $past(dat) == bkd_pkg::BYTE_ESC_END
  ) else $error("end key without its byte");
  a_replay_gap: assert property (
    $fell(scan_ready) |-> kv && key == bkd_pkg::KEY_STATUS ##1 scan_ready
  ) else $error("replay cycle wrong");
  a_sel_term: assert property (
    kv && key >= bkd_pkg::KEY_HELP |->
    $past(took) && $past(dat) == bkd_pkg::BYTE_ENTER
  ) else $error("function key without terminator");
  a_hot_term: assert property (
    hv |-> $past(took) && $past(dat) == bkd_pkg::BYTE_ENTER
  ) else $error("hot key without terminator");
  a_hot_pulse: assert property (
    hv |=> !hv
  ) else $error("hot key pulse too long");
  a_short_field: assert property (
    hv && hot_out.kind != bkd_pkg::HOT_EMPLOYEE |-> hot_out.bcd[27:8] == 20'h0
  ) else $error("two digit field too wide");
  a_drop_alone: assert property (
    seq_drop |-> !kv && !hv
  ) else $error("event on a dropped sequence");
endmodule : bkd_decoder_checker

bind bkd_decoder bkd_decoder_checker #(.ESC_WAIT(ESC_WAIT))
  i_bkd_decoder_checker (.core_clk(core_clk), .rst_n(rst_n),
  .scan_in(scan_in), .scan_ready(scan_ready), .key_out(key_out),
  .hot_out(hot_out), .seq_drop(seq_drop));

// *** verif/bkd_scanner_model.sv ***
// Behavioural barcode scanner that sends whole codes.
`timescale 1ns/1ps
module bkd_scanner_model (
  // Clock
  input wire logic core_clk,
  // Byte stream
  input wire logic scan_ready,
  output bkd_pkg::bkd_byte_t scan_in
);
  int gap = 0;
  initial scan_in = 9'h05a;

  // One label is one whole code, one ASCII byte per value
  task automatic send(input logic [7:0] code [$]);
    logic rdy;
    foreach (code[i]) begin
      scan_in = {1'b1, code[i]};
      do begin
        rdy = scan_ready;
        @(posedge core_clk) #1;
      end while (rdy !== 1'b1);
      // A released line shows the inverse, so no stale byte passes.
      if (gap > 0 || i == code.size() - 1) begin
        scan_in = {1'b0, ~scan_in.data};
        // An edge always passes after a release, so two labels never meet.
        repeat (gap > 0 ? gap : 1) @(posedge core_clk) #1;
      end
    end
  endtask : send
endmodule : bkd_scanner_model

// *** verif/bkd_decoder_tb.sv ***
// Self-checking bench for the barcode keystroke decoder.
`timescale 1ns/1ps
module bkd_decoder_tb;
  // ------------------------------------------------------------
  // Clock, reset and instances
  // ------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scan_ready;
  logic seq_drop;
  bkd_pkg::bkd_byte_t scan_in;
  bkd_pkg::bkd_key_evt_t key_out;
  bkd_pkg::bkd_hot_evt_t hot_out;
  int err_count = 0;
  int n_compared = 0;
  int drop_n = 0;
  bkd_pkg::bkd_key_t key_q [$];
  bkd_pkg::bkd_hot_evt_t hot_q [$];
  always #2 core_clk = ~core_clk;
  bkd_decoder #(.ESC_WAIT(16)) i_bkd_decoder (.core_clk(core_clk),
    .rst_n(rst_n), .scan_in(scan_in), .scan_ready(scan_ready),
    .key_out(key_out), .hot_out(hot_out), .seq_drop(seq_drop));
  bkd_scanner_model i_bkd_scanner_model (.core_clk(core_clk),
    .scan_ready(scan_ready), .scan_in(scan_in));
  // Pulses last one cycle, so the falling edge sees each exactly once.
  always @(negedge core_clk) begin
    if (key_out.valid === 1'b1) key_q.push_back(key_out.key);
    if (hot_out.valid === 1'b1) hot_q.push_back(hot_out);
    if (seq_drop === 1'b1) drop_n++;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic cmp_val(input string what, input logic [27:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : cmp_val
  task automatic cmp_key(input string what, input bkd_pkg::bkd_key_t exp);
    bkd_pkg::bkd_key_t got;
    got = key_q.size() > 0 ? key_q.pop_front() : bkd_pkg::bkd_key_t'(5'h1f);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : cmp_key
  task automatic run(input logic [7:0] code [$]);
    key_q.delete();
    hot_q.delete();
    drop_n = 0;
    i_bkd_scanner_model.send(code);
    repeat (24) @(posedge core_clk) #1;
  endtask : run
  task automatic hot(input logic [7:0] code [$], input logic [1:0] kind,
                     input logic [27:0] bcd);
    run(code);
    cmp_val("hot events", 28'h1, 28'(hot_q.size()));
    if (hot_q.size() > 0) begin
      cmp_val("hot kind", 28'(kind), 28'(hot_q[0].kind));
      cmp_val("hot digits", bcd, hot_q[0].bcd);
    end
  endtask : hot
  task automatic bad(input logic [7:0] code [$]);
    run(code);
    cmp_val("drops", 28'h1, 28'(drop_n));
    cmp_val("events", 28'h0, 28'(key_q.size() + hot_q.size()));
    run('{8'h0d});
    cmp_key("enter after drop", bkd_pkg::KEY_ENTER);
  endtask : bad

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_keys;
    logic [7:0] one [6] = '{8'h0d, 8'h0c, 8'h08, 8'h0b, 8'h0a, 8'h1e};
    logic [7:0] esc [4] = '{8'h54, 8'h57, 8'h4a, 8'h4b};
    foreach (one[i]) begin
      run('{one[i]});
      // Status sits between Enter and the arrows in the key order.
      cmp_key("single", bkd_pkg::bkd_key_t'(i == 0 ? 0 : i + 1));
    end
    foreach (esc[i]) begin
      run('{8'h1b, esc[i]});
      cmp_key("escape pair", bkd_pkg::bkd_key_t'(7 + i));
    end
    run('{8'h1b});
    cmp_key("lone escape", bkd_pkg::KEY_STATUS);
    i_bkd_scanner_model.send('{8'h1b});
    run('{8'h1e});
    cmp_key("escape resolved", bkd_pkg::KEY_STATUS);
    cmp_key("replayed byte", bkd_pkg::KEY_HOME);
    cmp_val("ready after replay", 28'h1, 28'(scan_ready));
    $display("test keys done");
  endtask : t_keys
  task automatic t_select;
    for (int i = 0; i < 10; i++) begin
      run('{8'h01, 8'h40 + 8'(i), 8'h0d});
      cmp_key("select", bkd_pkg::bkd_key_t'(bkd_pkg::KEY_HELP + i));
    end
    $display("test select done");
  endtask : t_select
  task automatic t_hot;
    logic [7:0] emp [$] = '{8'h01, 8'h61, 8'h0d, 8'h39, 8'h38, 8'h37,
                            8'h36, 8'h35, 8'h30, 8'h31, 8'h0d};
    hot('{8'h01, 8'h60, 8'h0d, 8'h34, 8'h32, 8'h0d}, 2'h0, 28'h42);
    hot(emp, 2'h1, 28'h9876501);
    i_bkd_scanner_model.gap = 3;
    hot('{8'h01, 8'h63, 8'h0d, 8'h39, 8'h30, 8'h0d}, 2'h2, 28'h90);
    i_bkd_scanner_model.gap = 0;
    $display("test hot done");
  endtask : t_hot
  task automatic t_drop;
    bad('{8'h00});
    bad('{8'h01, 8'h50, 8'h0d});
    bad('{8'h01, 8'h40, 8'h00});
    bad('{8'h01, 8'h60, 8'h0d, 8'h34, 8'h41});
    bad('{8'h01, 8'h60, 8'h0d, 8'h34, 8'h0d});
    bad('{8'h01, 8'h63, 8'h0d, 8'h31, 8'h32, 8'h33});
    $display("test drop done");
  endtask : t_drop

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge core_clk) #1;
    t_keys();
    t_select();
    t_hot();
    t_drop();
    close_out();
  end
  initial begin
    #200000;
    err_count++;
    close_out();
  end
endmodule : bkd_decoder_tb
